// ### hw/catb_timebase.sv
// Overview of operation
// - Select bits pick osc/12, osc/4, timer 0 overflow or external pin.
// - Double-speed mode divides by 6 and 2 instead of 12 and 4.
// - One 16-bit counter is the shared time base of five modules.
// - Module modes live in each module; this block feeds their time base.
// - Watchdog enable bit turns module 4 watchdog on when 1.
// - Capture, timer and output modules may raise an interrupt on events.
// - Five module events and overflow merge into one interrupt line.
// - Port 1 bit 2 is count input; bits 3..7 serve modules, else I/O.
// - Idle gate bit 0 keeps counting in idle; 1 stops it.
// - Run bit set by software starts counter; cleared, counter stops.
// - Overflow flag, control bit 7, sets when counter rolls over.
// - Overflow flag requests interrupt only with overflow enable set.
// - Software may set or clear overflow flag; hardware never clears it.
// - Control bits 0..4 are module event flags, set on match or capture.
// - Module event flags are cleared only by software writes.
`timescale 1ns/1ps
`default_nettype none
`include "catb_consts.svh"

module catb_timebase
#(
   parameter int N_MODULES = 5
)
(
   input  wire logic                   mclk_in,
   input  wire logic                   rstn_in,
   input  wire catb_pkg::catb_sfr_req_s sfr_req_in,
   output logic                        sfr_hit_out,
   output logic [7:0]                  sfr_rdata_out,
   input  wire logic                   double_speed_mode_in,
   input  wire logic                   idle_mode_in,
   input  wire logic                   timer0_ovf_in,
   input  wire logic [N_MODULES-1:0]   module_event_in,
   input  wire logic [N_MODULES-1:0]   module_irq_en_in,
   input  wire logic [N_MODULES-1:0]   module_pin_use_in,
   input  wire logic [N_MODULES-1:0]   module_pin_drive_in,
   input  wire logic [N_MODULES-1:0]   module_pin_oe_in,
   output logic [N_MODULES-1:0]        module_pin_out,
   input  wire logic [7:0]             port1_pin_in,
   input  wire logic [7:0]             port1_latch_in,
   input  wire logic [7:0]             port1_latch_oe_in,
   output logic [7:0]                  port1_pin_out,
   output logic [7:0]                  port1_pin_oe_out,
   output logic [15:0]                 count_out,
   output logic                        count_tick_out,
   output logic                        watchdog_enable_bit_out,
   output logic                        irq_out
);
   import catb_pkg::*;

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic                 overflow_flag_q;
   logic                 run_control_bit_q;
   logic [N_MODULES-1:0] event_flag_q;
   logic                 idle_gate_bit_q;
   logic                 watchdog_enable_bit_q;
   logic [1:0]           count_source_sel_q;
   logic                 overflow_irq_enable_q;
   logic [7:0]           rdata_q;
   logic [3:0]           presc_q;
   logic [3:0]           presc_d;
   logic [3:0]           div_ratio;
   logic                 presc_tick;
   logic [15:0]          count_q;
   logic                 ext_s1_q;
   logic                 ext_s2_q;
   logic                 ext_s3_q;
   logic                 ext_level_q;
   logic                 ext_fall;
   logic                 count_enable;
   logic                 count_tick;
   logic                 rollover;
   logic                 wr_control;
   logic                 wr_mode;
   logic                 hit_control;
   logic                 hit_mode;
   logic [7:0]           control_view;
   logic [7:0]           mode_view;
   logic [7:0]           pin_out_d;
   logic [7:0]           pin_oe_d;
   logic [7:0]           pin_out_q;
   logic [7:0]           pin_oe_q;
   catb_src_e            src_sel;

   // ****************************************************************
   // Register bus decode
   // ****************************************************************

   // Address match for both registers
   assign hit_control = (sfr_req_in.addr == `CATB_ADDR_CONTROL);
   assign hit_mode    = (sfr_req_in.addr == `CATB_ADDR_MODE);
   assign sfr_hit_out = hit_control | hit_mode;
   assign wr_control  = sfr_req_in.wr & hit_control;
   assign wr_mode     = sfr_req_in.wr & hit_mode;

   // Read views; reserved bits read as zero
   always_comb
   begin
      control_view = `CATB_RST_BYTE;
      control_view[`CATB_CTL_OVF_BIT] = overflow_flag_q;
      control_view[`CATB_CTL_RUN_BIT] = run_control_bit_q;
      control_view[`CATB_CTL_EVT_MSB:`CATB_CTL_EVT_LSB] = event_flag_q;
   end

   // Mode view packs configuration bits at their fixed places
   always_comb
   begin
      mode_view = `CATB_RST_BYTE;
      mode_view[`CATB_MOD_IDLE_BIT]   = idle_gate_bit_q;
      mode_view[`CATB_MOD_WDOG_BIT]   = watchdog_enable_bit_q;
      mode_view[`CATB_MOD_SRC_HI_BIT] = count_source_sel_q[1];
      mode_view[`CATB_MOD_SRC_LO_BIT] = count_source_sel_q[0];
      mode_view[`CATB_MOD_OVFIE_BIT]  = overflow_irq_enable_q;
   end

   // Read data registered; unmapped addresses return zero
   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
         rdata_q <= `CATB_RST_BYTE;
      else if (sfr_req_in.rd)
      begin
         if (hit_control)
            rdata_q <= control_view;
         else if (hit_mode)
            rdata_q <= mode_view;
         else
            rdata_q <= `CATB_RST_BYTE;
      end
   end

   assign sfr_rdata_out = rdata_q;

   // ****************************************************************
   // Mode register
   // ****************************************************************

   // Reserved bits are simply not stored, so stray ones do no harm
   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
      begin
         idle_gate_bit_q       <= 1'b0;
         watchdog_enable_bit_q <= 1'b0;
         count_source_sel_q    <= 2'b00;
         overflow_irq_enable_q <= 1'b0;
      end
      else if (wr_mode)
      begin
         idle_gate_bit_q       <= sfr_req_in.wdata[`CATB_MOD_IDLE_BIT];
         watchdog_enable_bit_q <= sfr_req_in.wdata[`CATB_MOD_WDOG_BIT];
         count_source_sel_q    <= {sfr_req_in.wdata[`CATB_MOD_SRC_HI_BIT],
                                   sfr_req_in.wdata[`CATB_MOD_SRC_LO_BIT]};
         overflow_irq_enable_q <= sfr_req_in.wdata[`CATB_MOD_OVFIE_BIT];
      end
   end

   assign watchdog_enable_bit_out = watchdog_enable_bit_q;

   // ****************************************************************
   // Control register
   // ****************************************************************

   // Run bit belongs to software only
   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
         run_control_bit_q <= 1'b0;
      else if (wr_control)
         run_control_bit_q <= sfr_req_in.wdata[`CATB_CTL_RUN_BIT];
   end

   // Overflow flag: software writes either way, rollover wins the cycle
   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
         overflow_flag_q <= 1'b0;
      else if (rollover)
         overflow_flag_q <= 1'b1;
      else if (wr_control)
         overflow_flag_q <= sfr_req_in.wdata[`CATB_CTL_OVF_BIT];
   end

   // Module event flags: set by hardware, cleared only by writes
   genvar gi;
   generate
      for (gi = 0; gi < N_MODULES; gi++)
      begin : g_event
         always_ff @(posedge mclk_in)
         begin
            if (!rstn_in)
               event_flag_q[gi] <= 1'b0;
            else if (module_event_in[gi])
               event_flag_q[gi] <= 1'b1;
            else if (wr_control)
               event_flag_q[gi] <= sfr_req_in.wdata[`CATB_CTL_EVT_LSB + gi];
         end
      end
   endgenerate

   // ****************************************************************
   // External count input synchroniser
   // ****************************************************************

   // Three stages; a level is accepted once stages two and three agree
   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
      begin
         ext_s1_q <= 1'b1;
         ext_s2_q <= 1'b1;
         ext_s3_q <= 1'b1;
      end
      else
      begin
         ext_s1_q <= port1_pin_in[`CATB_PIN_EXT];
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   // Accepted level; idles high like an unloaded port pin
   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
         ext_level_q <= 1'b1;
      else if (ext_s2_q == ext_s3_q)
         ext_level_q <= ext_s3_q;
   end

   // Falling edge counts; each level must last two clocks, so input no faster than osc/4
   assign ext_fall = ext_level_q & (ext_s2_q == ext_s3_q) & ~ext_s3_q;

   // ****************************************************************
   // Prescaler and count source
   // ****************************************************************

   assign src_sel = catb_src_e'(count_source_sel_q);

   // Ratio follows the speed mode at once; a running count wraps safely
   always_comb
   begin
      div_ratio = `CATB_DIV12_N;
      unique case (src_sel)
         CATB_SRC_DIV12: div_ratio = double_speed_mode_in ? `CATB_DIV6_N : `CATB_DIV12_N;
         CATB_SRC_DIV4:  div_ratio = double_speed_mode_in ? `CATB_DIV2_N : `CATB_DIV4_N;
         CATB_SRC_T0OVF: div_ratio = `CATB_DIV12_N;
         CATB_SRC_EXT:   div_ratio = `CATB_DIV12_N;
      endcase
   end

   // Counting allowed only while running and not gated by idle
   assign count_enable = run_control_bit_q & ~(idle_mode_in & idle_gate_bit_q);

   // Tick at the last prescaler step; >= covers a ratio shrinking mid-count
   assign presc_tick = (presc_q >= (div_ratio - `CATB_PRESC_ONE));

   always_comb
   begin
      if (!count_enable)
         presc_d = `CATB_PRESC_ZERO;
      else if (presc_tick)
         presc_d = `CATB_PRESC_ZERO;
      else
         presc_d = presc_q + `CATB_PRESC_ONE;
   end

   // Prescaler held at zero when stopped so restarts give a full period
   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
         presc_q <= `CATB_PRESC_ZERO;
      else
         presc_q <= presc_d;
   end

   // One count pulse from whichever source is selected
   always_comb
   begin
      count_tick = 1'b0;
      unique case (src_sel)
         CATB_SRC_DIV12: count_tick = presc_tick;
         CATB_SRC_DIV4:  count_tick = presc_tick;
         CATB_SRC_T0OVF: count_tick = timer0_ovf_in;
         CATB_SRC_EXT:   count_tick = ext_fall;
      endcase
      count_tick = count_tick & count_enable;
   end

   // ****************************************************************
   // Shared 16-bit time base
   // ****************************************************************

   assign rollover = count_tick & (count_q == `CATB_COUNT_MAX);

   // Plain wrap-around counter shared by all modules
   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
         count_q <= `CATB_RST_COUNT;
      else if (count_tick)
         count_q <= count_q + `CATB_COUNT_ONE;
   end

   assign count_out      = count_q;
   assign count_tick_out = count_tick;  // Modules compare on this pulse

   // ****************************************************************
   // Shared interrupt request
   // ****************************************************************

   // Module flags pass only where that module's mode allows an interrupt
   assign irq_out = (overflow_flag_q & overflow_irq_enable_q)
                  | (|(event_flag_q & module_irq_en_in));

   // ****************************************************************
   // Port 1 pin sharing
   // ****************************************************************

   // Modules see raw pins; their own capture logic synchronises them
   assign module_pin_out = port1_pin_in[`CATB_PIN_MOD0 + N_MODULES - 1:`CATB_PIN_MOD0];

   // Each pin goes to its module when used, else stays standard I/O
   genvar gp;
   generate
      for (gp = 0; gp < 8; gp++)
      begin : g_pin
         if ((gp >= `CATB_PIN_MOD0) && (gp < `CATB_PIN_MOD0 + N_MODULES))
         begin : g_mod
            assign pin_out_d[gp] = module_pin_use_in[gp - `CATB_PIN_MOD0]
                                 ? module_pin_drive_in[gp - `CATB_PIN_MOD0]
                                 : port1_latch_in[gp];
            assign pin_oe_d[gp]  = module_pin_use_in[gp - `CATB_PIN_MOD0]
                                 ? module_pin_oe_in[gp - `CATB_PIN_MOD0]
                                 : port1_latch_oe_in[gp];
         end
         else
         begin : g_io
            assign pin_out_d[gp] = port1_latch_in[gp];
            assign pin_oe_d[gp]  = port1_latch_oe_in[gp];
         end
      end
   endgenerate

   // Registered pin drive; costs one cycle, avoids glitching the pads
   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
      begin
         pin_out_q <= `CATB_RST_BYTE;
         pin_oe_q  <= `CATB_RST_BYTE;
      end
      else
      begin
         pin_out_q <= pin_out_d;
         pin_oe_q  <= pin_oe_d;
      end
   end

   assign port1_pin_out    = pin_out_q;
   assign port1_pin_oe_out = pin_oe_q;

endmodule

`default_nettype wire

// ### hw/catb_consts.svh
`ifndef CATB_CONSTS_SVH
`define CATB_CONSTS_SVH

// ****************************************************************
// Register addresses on the special function register bus
// ****************************************************************
`define CATB_ADDR_CONTROL     8'hD8
`define CATB_ADDR_MODE        8'hD9

// ****************************************************************
// Control register field positions
// ****************************************************************
`define CATB_CTL_OVF_BIT      7
`define CATB_CTL_RUN_BIT      6
`define CATB_CTL_EVT_LSB      0
`define CATB_CTL_EVT_MSB      4

// ****************************************************************
// Mode register field positions
// ****************************************************************
`define CATB_MOD_IDLE_BIT     7
`define CATB_MOD_WDOG_BIT     6
`define CATB_MOD_SRC_HI_BIT   2
`define CATB_MOD_SRC_LO_BIT   1
`define CATB_MOD_OVFIE_BIT    0

// ****************************************************************
// Reset values and divide ratios
// ****************************************************************
`define CATB_RST_BYTE         8'h00
`define CATB_RST_EVT          5'h00
`define CATB_RST_COUNT        16'h0000
`define CATB_COUNT_ONE        16'h0001
`define CATB_COUNT_MAX        16'hFFFF
`define CATB_PRESC_ZERO       4'h0
`define CATB_PRESC_ONE        4'h1
`define CATB_DIV12_N          4'hC
`define CATB_DIV6_N           4'h6
`define CATB_DIV4_N           4'h4
`define CATB_DIV2_N           4'h2

// ****************************************************************
// Port 1 pin positions
// ****************************************************************
`define CATB_PIN_EXT          2
`define CATB_PIN_MOD0         3

`endif

// ### hw/catb_pkg.sv
package catb_pkg;

   // Request from the processor core towards the register bus
   typedef struct packed
   {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } catb_sfr_req_s;

   // Count source, in the order of the two select bits
   typedef enum logic [1:0]
   {
      CATB_SRC_DIV12,
      CATB_SRC_DIV4,
      CATB_SRC_T0OVF,
      CATB_SRC_EXT
   } catb_src_e;

endpackage

// ### tb/catb_timebase_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// *****
// Checker on the time base ports
// *****
module catb_timebase_asserts
#(
   parameter int N_MODULES = 5
)
(
   input wire logic                    mclk_in,
   input wire logic                    rstn_in,
   input wire catb_pkg::catb_sfr_req_s sfr_req_in,
   input wire logic                    idle_mode_in,
   input wire logic                    timer0_ovf_in,
   input wire logic [N_MODULES-1:0]    module_event_in,
   input wire logic [N_MODULES-1:0]    module_irq_en_in,
   input wire logic [N_MODULES-1:0]    module_pin_use_in,
   input wire logic [N_MODULES-1:0]    module_pin_drive_in,
   input wire logic [7:0]              port1_pin_in,
   input wire logic [7:0]              port1_latch_in,
   input wire logic [7:0]              port1_pin_out,
   input wire logic [15:0]             count_out,
   input wire logic                    count_tick_out,
   input wire logic                    watchdog_enable_bit_out,
   input wire logic                    irq_out
);
   import catb_pkg::*;
   logic [7:0] mode_q;
   logic       run_q;
   logic       en;
   logic [7:0] pin_exp;

   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);

   // Shadow of what the core wrote, so the gating can be predicted
   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
      begin
         mode_q <= 8'h00;
         run_q  <= 1'b0;
      end
      else if (sfr_req_in.wr)
      begin
         if (sfr_req_in.addr == 8'hD9) mode_q <= sfr_req_in.wdata;
         if (sfr_req_in.addr == 8'hD8) run_q <= sfr_req_in.wdata[6];
      end
   end

   // Expected count enable and pad drive
   assign en      = run_q & ~(idle_mode_in & mode_q[7]);
   assign pin_exp = {(module_pin_use_in & module_pin_drive_in) | (~module_pin_use_in & port1_latch_in[7:3]),
                     port1_latch_in[2:0]};

   a_tick_step: assert property (count_tick_out |=> count_out == $past(count_out) + 16'h0001)
      else $error("count did not step on tick");
   a_count_hold: assert property (!count_tick_out |=> $stable(count_out))
      else $error("count moved without tick");
   a_idle_gate: assert property (!en |-> !count_tick_out)
      else $error("tick while disabled");
   a_t0_count: assert property (mode_q[2:1] == 2'h2 && en && timer0_ovf_in |-> count_tick_out)
      else $error("timer 0 overflow not counted");
   a_ext_count: assert property (mode_q[2:1] == 2'h3 && en && $fell(port1_pin_in[2]) |-> ##3 count_tick_out)
      else $error("external fall not counted");
   a_ovf_irq: assert property (count_tick_out && count_out == 16'hFFFF && mode_q[0] |=> irq_out)
      else $error("rollover gave no request");
   a_irq_cause: assert property (irq_out |-> mode_q[0] || (|module_irq_en_in))
      else $error("request without enable");
   a_evt_irq: assert property ((|(module_event_in & module_irq_en_in)) ##1
                               module_irq_en_in == $past(module_irq_en_in) |-> irq_out)
      else $error("module event gave no request");
   a_wdog_write: assert property (sfr_req_in.wr && sfr_req_in.addr == 8'hD9
                                  |=> watchdog_enable_bit_out == $past(sfr_req_in.wdata[6]))
      else $error("watchdog enable not written");
   a_pin_route: assert property (rstn_in |=> port1_pin_out == $past(pin_exp))
      else $error("pad drive misrouted");
endmodule

bind catb_timebase catb_timebase_asserts #(.N_MODULES(N_MODULES)) i_catb_timebase_asserts
(
   .mclk_in(mclk_in), .rstn_in(rstn_in), .sfr_req_in(sfr_req_in), .idle_mode_in(idle_mode_in),
   .timer0_ovf_in(timer0_ovf_in), .module_event_in(module_event_in), .module_irq_en_in(module_irq_en_in),
   .module_pin_use_in(module_pin_use_in), .module_pin_drive_in(module_pin_drive_in),
   .port1_pin_in(port1_pin_in), .port1_latch_in(port1_latch_in), .port1_pin_out(port1_pin_out),
   .count_out(count_out), .count_tick_out(count_tick_out),
   .watchdog_enable_bit_out(watchdog_enable_bit_out), .irq_out(irq_out)
);
`default_nettype wire

// ### tb/catb_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// *****
// Processor core model on the SFR bus
// *****
module catb_core_model
(
   input  wire logic               mclk_in,
   output catb_pkg::catb_sfr_req_s req_out,
   input  wire logic [7:0]         rdata_in
);
   import catb_pkg::*;

   initial req_out = '0;

   // Reserved bits always go out as zero
   function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] v);
      return (a == 8'hD9) ? (v & 8'hC7) : (a == 8'hD8) ? (v & 8'hDF) : v;
   endfunction

   // Write held for one taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk_in) req_out <= '{1'b1, 1'b0, a, legal(a, v)};
      @(posedge mclk_in) req_out <= '0;
   endtask

   // Read data is registered, so it is taken one edge later
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge mclk_in) req_out <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge mclk_in) req_out <= '0;
      @(posedge mclk_in) v = rdata_in;
   endtask
endmodule
`default_nettype wire

// ### tb/catb_timebase_tb.sv
`timescale 1ns/1ps
`default_nettype none

module catb_timebase_tb;
   import catb_pkg::*;
   logic          mclk, hit, tick, wdog, irq;
   logic          rstn = 0, x2 = 0, idle = 0, t0 = 0;
   logic [4:0]    evt = 0, ien = 0, puse = 5'h15, pdrv = 5'h0A, poe = 5'h00, mpin;
   logic [7:0]    p1in = 8'hAC, p1lat = 8'h5A, p1loe = 8'hFF, rdata, p1out, p1oe, d;
   logic [15:0]   cnt, c0;
   catb_sfr_req_s req;
   int            failures = 0, checked = 0, n;
   int            ratio [4] = '{12, 4, 6, 2};

   catb_core_model i_catb_core_model (.mclk_in(mclk), .req_out(req), .rdata_in(rdata));

   catb_timebase #(.N_MODULES(5)) i_catb_timebase
   (
      .mclk_in(mclk), .rstn_in(rstn), .sfr_req_in(req), .sfr_hit_out(hit), .sfr_rdata_out(rdata),
      .double_speed_mode_in(x2), .idle_mode_in(idle), .timer0_ovf_in(t0), .module_event_in(evt),
      .module_irq_en_in(ien), .module_pin_use_in(puse), .module_pin_drive_in(pdrv),
      .module_pin_oe_in(poe), .module_pin_out(mpin), .port1_pin_in(p1in), .port1_latch_in(p1lat),
      .port1_latch_oe_in(p1loe), .port1_pin_out(p1out), .port1_pin_oe_out(p1oe), .count_out(cnt),
      .count_tick_out(tick), .watchdog_enable_bit_out(wdog), .irq_out(irq)
   );

   // 200 MHz clock
   initial
   begin
      mclk = 0;
      forever #2.5 mclk = ~mclk;
   end

   // *****
   // Shared tasks
   // *****
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      i_catb_core_model.wr(a, v);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      i_catb_core_model.rd(a, d);
      chk(d, e);
   endtask

   // Bounded wait for a tick, or for the wrap to zero when ovf is set
   task automatic wait_ev(input bit ovf, input int lim);
      n = 0;
      do
      begin
         @(negedge mclk);
         n++;
      end
      while (!(ovf ? cnt === 16'h0000 : tick === 1'b1) && n < lim);
      if (n >= lim)
      begin
         failures++;
         test_done();
      end
   endtask

   // *****
   // Main sequence
   // *****
   initial
   begin
      repeat (12) @(posedge mclk);
      rstn <= 1;
      repeat (2) @(negedge mclk);
      chk(p1out, 8'h52);
      chk(p1oe, 8'h57);
      chk(mpin, 5'h15);
      chk(hit, 1'b0);
      @(posedge mclk) puse <= 5'h0A;
      @(posedge mclk);
      @(negedge mclk);
      chk(p1out, 8'h5A);
      chk(p1oe, 8'hAF);
      fork
         rchk(8'hD8, 8'h00);
         begin
            @(negedge mclk);
            chk(hit, 1'b1);
         end
      join
      rchk(8'hD9, 8'h00);
      rchk(8'hDA, 8'h00);
      wr(8'hD9, 8'hC7);
      rchk(8'hD9, 8'hC7);
      chk(wdog, 1'b1);
      $display("test registers done");
      wr(8'hD8, 8'h40);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge mclk) x2 <= i[1];
         wr(8'hD9, i[0] ? 8'h02 : 8'h00);
         wait_ev(0, 200);
         wait_ev(0, 200);
         chk(n, ratio[i]);
      end
      wr(8'hD8, 8'h00);
      @(negedge mclk) c0 = cnt;
      repeat (20) @(negedge mclk);
      chk(cnt, c0);
      $display("test dividers done");
      wr(8'hD9, 8'h04);
      wr(8'hD8, 8'h40);
      @(negedge mclk) c0 = cnt;
      repeat (3)
      begin
         @(posedge mclk) t0 <= 1;
         @(posedge mclk) t0 <= 0;
      end
      @(negedge mclk) chk(cnt, c0 + 16'h3);
      wr(8'hD9, 8'h06);
      @(negedge mclk) c0 = cnt;
      // Each level held four clocks, twice the two clocks the input needs
      repeat (5)
      begin
         repeat (4) @(posedge mclk);
         p1in[2] <= 0;
         repeat (4) @(posedge mclk);
         p1in[2] <= 1;
      end
      repeat (6) @(negedge mclk);
      chk(cnt, c0 + 16'h5);
      $display("test sources done");
      wr(8'hD9, 8'h82);
      @(posedge mclk) idle <= 1;
      @(negedge mclk) c0 = cnt;
      repeat (20) @(negedge mclk);
      chk(cnt, c0);
      wr(8'hD9, 8'h02);
      repeat (20) @(negedge mclk);
      chk(cnt !== c0, 1'b1);
      @(posedge mclk) idle <= 0;
      $display("test idle done");
      // Back-to-back overflow pulses are the only way to wrap in time
      wr(8'hD9, 8'h05);
      @(posedge mclk) t0 <= 1;
      wait_ev(1, 70000);
      @(posedge mclk) t0 <= 0;
      rchk(8'hD8, 8'hC0);
      chk(irq, 1'b1);
      wr(8'hD9, 8'h04);
      @(negedge mclk);
      chk(irq, 1'b0);
      wr(8'hD8, 8'h00);
      rchk(8'hD8, 8'h00);
      wr(8'hD8, 8'h80);
      rchk(8'hD8, 8'h80);
      wr(8'hD8, 8'h00);
      $display("test overflow done");
      for (int i = 0; i < 5; i++)
         @(posedge mclk) evt <= 5'h01 << i;
      @(posedge mclk) evt <= 0;
      repeat (5) @(posedge mclk);
      rchk(8'hD8, 8'h1F);
      chk(irq, 1'b0);
      wr(8'hD8, 8'h00);
      rchk(8'hD8, 8'h00);
      @(posedge mclk) ien <= 5'h10;
      @(posedge mclk) evt <= 5'h10;
      @(posedge mclk) evt <= 0;
      @(negedge mclk) chk(irq, 1'b1);
      wr(8'hD8, 8'h00);
      @(negedge mclk);
      chk(irq, 1'b0);
      $display("test events done");
      test_done();
   end
endmodule
`default_nettype wire
